/* rtl/slm_defs.svh */
`ifndef SLM_DEFS_SVH
`define SLM_DEFS_SVH

// Register byte offsets
`define SLM_OFF_CTRL 8'h00
`define SLM_OFF_LIMIT 8'h04
`define SLM_OFF_TRIP 8'h08
`define SLM_OFF_LS_DELAY 8'h0C
`define SLM_OFF_ZS_DELAY 8'h10
`define SLM_OFF_STATUS 8'h14
`define SLM_OFF_IRQ_STATUS 8'h18
`define SLM_OFF_IRQ_MASK 8'h1C

// Control field positions
`define SLM_CTRL_REQ 0
`define SLM_CTRL_ACK 1
`define SLM_CTRL_MODE_LO 2
`define SLM_CTRL_MODE_HI 3
`define SLM_CTRL_TMON 4

// Interrupt bit positions
`define SLM_IRQ_HIT 0
`define SLM_IRQ_IND 1
`define SLM_IRQ_ZS 2
`define SLM_IRQ_REJ 3

// Reset values
`define SLM_RST_LIMIT 16'h1000
`define SLM_RST_TRIP 16'h1400
`define SLM_RST_LS_DELAY 32'h0000_1000
`define SLM_RST_ZS_DELAY 32'h0000_1000
`define SLM_RST_MODE 2'h2
`define SLM_RST_IRQ_MASK 4'h0

// Speed assumed before any valid sample
`define SLM_SPEED_UNKNOWN 16'hFFFF

// AHB encodings
`define SLM_HSIZE_WORD 3'h2
`define SLM_HRESP_OKAY 1'b0

`endif

/* rtl/slm_pkg.sv */
package slm_pkg;

   typedef enum logic [1:0] {
      MODE_DELAY = 2'h0,
      MODE_MON_ACTIVE = 2'h1,
      MODE_DISABLED = 2'h2,
      MODE_SPARE = 2'h3
   } slm_mode_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DECEL = 6'h02,
      ST_MODLOSS = 6'h04,
      ST_MONITOR = 6'h08,
      ST_TRIPPED = 6'h10,
      ST_BOOTWAIT = 6'h20
   } slm_fsm_t;

   typedef struct packed {
      logic mod_on;
      logic fault;
      logic power_loss;
      logic coast;
      logic spd_valid;
      logic [15:0] speed;
   } slm_pins_t;

   typedef struct packed {
      logic request;
      logic time_mon;
      slm_mode_t mode;
      logic [15:0] limit;
      logic [15:0] trip;
      logic [31:0] ls_delay;
      logic [31:0] zs_delay;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
   } slm_regs_t;

   typedef struct packed {
      logic act;
      logic wr;
      logic [7:0] addr;
   } slm_ahb_t;

   typedef struct packed {
      logic start;
      logic clear;
   } slm_tmr_cmd_t;

   typedef struct packed {
      logic [31:0] count;
      logic running;
      logic expired;
      logic fired;
   } slm_tmr_t;

   typedef struct packed {
      slm_ahb_t ahb;
      slm_regs_t regs;
      slm_pins_t sync1;
      slm_pins_t sync2;
      slm_fsm_t fsm;
      logic boot_pending;
      logic speed_seen;
      logic [15:0] speed_est;
      slm_tmr_cmd_t ls_cmd;
      slm_tmr_cmd_t zs_cmd;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
      logic indication;
      logic limit_hit;
      logic restart_block;
      logic sto_request;
      logic ack_accepted;
      logic irq;
   } slm_state_t;

endpackage

/* rtl/slm_timer.sv */
`timescale 1ns/1ps
module slm_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input slm_pkg::slm_tmr_cmd_t cmd,
   input wire logic [31:0] load,
   output logic running,
   output logic expired,
   output logic fired
);
   import slm_pkg::*;

   slm_tmr_t s;
   slm_tmr_t next_s;

   // Restart reloads; expiry after load+1 enabled cycles
   always_comb begin
      next_s = s;
      next_s.fired = 1'b0;
      if (cmd.clear) begin
         next_s.count = 32'h0000_0000;
         next_s.running = 1'b0;
         next_s.expired = 1'b0;
      end else if (cmd.start) begin
         next_s.count = load;
         next_s.running = 1'b1;
         next_s.expired = 1'b0;
      end else if (s.running) begin
         if (s.count == 32'h0000_0000) begin
            next_s.running = 1'b0;
            next_s.expired = 1'b1;
            next_s.fired = 1'b1;
         end else begin
            next_s.count = s.count - 32'h0000_0001;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign running = s.running;
   assign expired = s.expired;
   assign fired = s.fired;
endmodule // slm_timer

/* rtl/slm_top.sv */
// Operation
// [R1] Request above trip limit starts the limited-speed delay counter.
// [R2] Disabled mode: loss gives no torque-off, starts zero-speed delay.
// [R3] Modulation still lost at zero-speed expiry raises the indication.
// [R4] Disabled mode: limited-speed delay supervision stops on loss; the code keeps that delay running and checks its expiry on return.
// [R5] After loss, wait for zero-speed expiry or return, first wins.
// [R6] On modulation return the drive resumes deceleration toward the limit.
// [R7] Speed at midpoint of limit and trip starts monitoring and indication.
// [R8] Monitoring starts at latest when the limited-speed delay expires.
// [R9] Time-monitored: late return above trip limit raises a limit hit.
// [R10] Before valid speed data, speed is taken as very high.
// [R11] Request at reboot in delay or active mode blocks restart until expiry.
// [R12] Torque-off acknowledgement rejected until zero-speed delay expires.
// [R13] Early acknowledgement restarts the zero-speed delay from the start.
// [R14] Zero-speed expiry after reboot permits acknowledge, raises indication.
// [R15] Fault trip, power loss or coast stop count as modulation loss.
// [R16] Monitoring-active mode freezes the speed estimate on modulation loss.
`timescale 1ns/1ps
`include "slm_defs.svh"
module slm_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic modulation_on,
   input wire logic drive_fault,
   input wire logic drive_power_loss,
   input wire logic coast_stop,
   input wire logic speed_valid,
   input wire logic [15:0] speed,
   output logic sls_indication,
   output logic limit_hit,
   output logic restart_block,
   output logic sto_request,
   output logic ack_accepted,
   output logic irq
);
   import slm_pkg::*;

   slm_state_t s;
   slm_state_t next_s;
   logic ls_running;
   logic ls_expired;
   logic ls_fired;
   logic zs_running;
   logic zs_expired;
   logic zs_fired;

   function automatic logic is_reg(input logic [7:0] a,
                                   input logic [7:0] off);
      is_reg = (a == off);
   endfunction

   slm_timer u_ls_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .cmd(s.ls_cmd),
      .load(s.regs.ls_delay),
      .running(ls_running),
      .expired(ls_expired),
      .fired(ls_fired)
   );

   slm_timer u_zs_timer (
      .hclk(hclk),
      .hresetn(hresetn),
      .cmd(s.zs_cmd),
      .load(s.regs.zs_delay),
      .running(zs_running),
      .expired(zs_expired),
      .fired(zs_fired)
   );

   always_comb begin
      slm_pins_t pins_in;
      logic mod_lost;
      logic [16:0] sum;
      logic [15:0] midpoint;
      logic over_trip;
      logic at_mid;
      logic wr_ok;
      logic ack;
      logic [3:0] ev;
      logic [3:0] w1c;
      logic [31:0] status_word;
      pins_in = '0;
      mod_lost = 1'b0;
      sum = 17'h0_0000;
      midpoint = 16'h0000;
      over_trip = 1'b0;
      at_mid = 1'b0;
      wr_ok = 1'b0;
      ack = 1'b0;
      ev = 4'h0;
      w1c = 4'h0;
      status_word = 32'h0000_0000;
      next_s = s;

      // Pin inputs, two stages before use
      pins_in.mod_on = modulation_on;
      pins_in.fault = drive_fault;
      pins_in.power_loss = drive_power_loss;
      pins_in.coast = coast_stop;
      pins_in.spd_valid = speed_valid;
      pins_in.speed = speed;
      next_s.sync1 = pins_in;
      next_s.sync2 = s.sync1;

      mod_lost = !s.sync2.mod_on || s.sync2.fault || // R15
                 s.sync2.power_loss || s.sync2.coast; // R15

      // Speed estimate
      if (!s.speed_seen) begin
         next_s.speed_est = `SLM_SPEED_UNKNOWN; // R10
      end
      if (s.regs.mode == MODE_MON_ACTIVE && mod_lost) begin
         next_s.speed_est = s.speed_est; // R16
      end else if (s.sync2.spd_valid) begin
         next_s.speed_est = s.sync2.speed;
         next_s.speed_seen = 1'b1;
      end

      sum = {1'b0, s.regs.limit} + {1'b0, s.regs.trip};
      midpoint = sum[16:1];
      over_trip = s.speed_est > s.regs.trip;
      at_mid = s.speed_est <= midpoint;

      // Bus data phase
      wr_ok = s.ahb.act && s.ahb.wr;
      ack = wr_ok && is_reg(s.ahb.addr, `SLM_OFF_CTRL) &&
            hwdata[`SLM_CTRL_ACK];
      if (wr_ok) begin
         if (is_reg(s.ahb.addr, `SLM_OFF_CTRL)) begin
            next_s.regs.request = hwdata[`SLM_CTRL_REQ];
            next_s.regs.time_mon = hwdata[`SLM_CTRL_TMON];
            next_s.regs.mode = slm_mode_t'(
               hwdata[`SLM_CTRL_MODE_HI:`SLM_CTRL_MODE_LO]);
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_LIMIT)) begin
            next_s.regs.limit = hwdata[15:0];
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_TRIP)) begin
            next_s.regs.trip = hwdata[15:0];
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_LS_DELAY)) begin
            next_s.regs.ls_delay = hwdata;
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_ZS_DELAY)) begin
            next_s.regs.zs_delay = hwdata;
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_IRQ_STATUS)) begin
            w1c = hwdata[3:0];
         end
         if (is_reg(s.ahb.addr, `SLM_OFF_IRQ_MASK)) begin
            next_s.regs.irq_mask = hwdata[3:0];
         end
      end

      // Supervisor sequence
      next_s.ls_cmd = '0;
      next_s.zs_cmd = '0;
      next_s.limit_hit = 1'b0;
      next_s.ack_accepted = 1'b0;
      unique case (s.fsm)
         ST_IDLE: begin
            next_s.indication = 1'b0;
            next_s.sto_request = 1'b0;
            next_s.restart_block = 1'b0;
            if (s.regs.request) begin
               if (s.boot_pending && s.regs.mode != MODE_DISABLED) begin
                  next_s.zs_cmd.start = 1'b1; // R11
                  next_s.restart_block = 1'b1; // R11
                  next_s.fsm = ST_BOOTWAIT;
               end else if (over_trip) begin
                  next_s.ls_cmd.start = 1'b1; // R1
                  next_s.boot_pending = 1'b0;
                  next_s.fsm = ST_DECEL;
               end else begin
                  next_s.boot_pending = 1'b0;
                  next_s.indication = 1'b1;
                  next_s.fsm = ST_MONITOR;
               end
            end
            if (ack) begin
               next_s.ack_accepted = 1'b1;
            end
         end
         ST_DECEL: begin
            if (!s.regs.request) begin
               next_s.ls_cmd.clear = 1'b1;
               next_s.fsm = ST_IDLE;
            end else if (mod_lost && s.regs.mode == MODE_DISABLED) begin
               next_s.zs_cmd.start = 1'b1; // R2
               next_s.fsm = ST_MODLOSS; // R4
            end else if (ls_expired) begin
               if (s.regs.time_mon && over_trip) begin
                  next_s.limit_hit = 1'b1;
                  ev[`SLM_IRQ_HIT] = 1'b1;
                  next_s.sto_request = 1'b1;
                  next_s.fsm = ST_TRIPPED;
               end else begin
                  next_s.indication = 1'b1; // R8
                  next_s.fsm = ST_MONITOR; // R8
               end
            end else if (at_mid) begin
               next_s.indication = 1'b1; // R7
               next_s.fsm = ST_MONITOR; // R7
            end
         end
         ST_MODLOSS: begin
            // Limited-speed delay expiry is ignored here; only its level is kept
            if (!s.regs.request) begin
               next_s.zs_cmd.clear = 1'b1;
               next_s.ls_cmd.clear = 1'b1;
               next_s.fsm = ST_IDLE;
            end else if (!mod_lost) begin
               next_s.zs_cmd.clear = 1'b1; // R5
               if (ls_expired && s.regs.time_mon && over_trip) begin
                  next_s.limit_hit = 1'b1; // R9
                  ev[`SLM_IRQ_HIT] = 1'b1; // R9
                  next_s.sto_request = 1'b1;
                  next_s.fsm = ST_TRIPPED;
               end else if (ls_expired) begin
                  next_s.indication = 1'b1; // R8
                  next_s.fsm = ST_MONITOR;
               end else begin
                  next_s.fsm = ST_DECEL; // R6
               end
            end else if (zs_fired) begin
               next_s.indication = 1'b1; // R3
               next_s.fsm = ST_MONITOR; // R5
            end
         end
         ST_MONITOR: begin
            next_s.indication = 1'b1;
            if (!s.regs.request) begin
               next_s.ls_cmd.clear = 1'b1;
               next_s.zs_cmd.clear = 1'b1;
               next_s.fsm = ST_IDLE;
            end else if (over_trip) begin
               next_s.indication = 1'b0;
               next_s.limit_hit = 1'b1;
               ev[`SLM_IRQ_HIT] = 1'b1;
               next_s.sto_request = 1'b1;
               next_s.fsm = ST_TRIPPED;
            end
            if (ack) begin
               next_s.ack_accepted = 1'b1;
            end
         end
         ST_TRIPPED: begin
            next_s.indication = 1'b0;
            if (ack) begin
               next_s.ack_accepted = 1'b1;
               next_s.ls_cmd.clear = 1'b1;
               next_s.zs_cmd.clear = 1'b1;
               next_s.fsm = ST_IDLE;
            end
         end
         ST_BOOTWAIT: begin
            next_s.restart_block = 1'b1;
            if (zs_fired && !ack) begin
               next_s.restart_block = 1'b0; // R14
               next_s.indication = 1'b1; // R14
               next_s.boot_pending = 1'b0;
               next_s.fsm = ST_MONITOR;
            end else if (ack) begin
               next_s.zs_cmd.start = 1'b1; // R13
               ev[`SLM_IRQ_REJ] = 1'b1; // R12
            end
         end
         default: begin
            next_s.fsm = ST_IDLE;
         end
      endcase

      ev[`SLM_IRQ_IND] = next_s.indication && !s.indication;
      ev[`SLM_IRQ_ZS] = zs_fired;
      // Set wins over a clear in the same cycle
      next_s.regs.irq_status = (s.regs.irq_status & ~w1c) | ev;
      next_s.irq = |(next_s.regs.irq_status & next_s.regs.irq_mask);

      // Bus address phase, zero wait states
      status_word[5:0] = s.fsm;
      status_word[6] = s.indication;
      status_word[7] = s.restart_block;
      status_word[8] = s.sto_request;
      status_word[9] = ls_expired;
      status_word[10] = s.boot_pending;
      status_word[11] = mod_lost;
      status_word[12] = zs_running;
      status_word[13] = ls_running;
      status_word[31:16] = s.speed_est;
      next_s.hreadyout = 1'b1;
      next_s.hresp = `SLM_HRESP_OKAY;
      next_s.ahb.act = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_s.ahb.act = (hsize == `SLM_HSIZE_WORD);
         next_s.ahb.wr = hwrite;
         next_s.ahb.addr = haddr[7:0];
         next_s.hrdata = 32'h0000_0000;
         if (!hwrite) begin
            if (is_reg(haddr[7:0], `SLM_OFF_CTRL)) begin
               next_s.hrdata[`SLM_CTRL_REQ] = s.regs.request;
               next_s.hrdata[`SLM_CTRL_MODE_HI:`SLM_CTRL_MODE_LO] =
                  s.regs.mode;
               next_s.hrdata[`SLM_CTRL_TMON] = s.regs.time_mon;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_LIMIT)) begin
               next_s.hrdata[15:0] = s.regs.limit;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_TRIP)) begin
               next_s.hrdata[15:0] = s.regs.trip;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_LS_DELAY)) begin
               next_s.hrdata = s.regs.ls_delay;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_ZS_DELAY)) begin
               next_s.hrdata = s.regs.zs_delay;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_STATUS)) begin
               next_s.hrdata = status_word;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_IRQ_STATUS)) begin
               next_s.hrdata[3:0] = s.regs.irq_status;
            end
            if (is_reg(haddr[7:0], `SLM_OFF_IRQ_MASK)) begin
               next_s.hrdata[3:0] = s.regs.irq_mask;
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.fsm <= ST_IDLE;
         s.boot_pending <= 1'b1;
         s.speed_est <= `SLM_SPEED_UNKNOWN;
         s.regs.limit <= `SLM_RST_LIMIT;
         s.regs.trip <= `SLM_RST_TRIP;
         s.regs.ls_delay <= `SLM_RST_LS_DELAY;
         s.regs.zs_delay <= `SLM_RST_ZS_DELAY;
         s.regs.mode <= slm_mode_t'(`SLM_RST_MODE);
         s.regs.irq_mask <= `SLM_RST_IRQ_MASK;
         s.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign sls_indication = s.indication;
   assign limit_hit = s.limit_hit;
   assign restart_block = s.restart_block;
   assign sto_request = s.sto_request;
   assign ack_accepted = s.ack_accepted;
   assign irq = s.irq;
endmodule // slm_top

/* verification/slm_drive_model.sv */
`timescale 1ns/1ps
module slm_drive_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic vld_en,
   input wire logic load,
   input wire logic ramp,
   input wire logic [2:0] cause,
   input wire logic [15:0] tgt,
   output logic modulation_on,
   output logic drive_fault,
   output logic drive_power_loss,
   output logic coast_stop,
   output logic speed_valid,
   output logic [15:0] speed
);
   logic [1:0] tick;
   assign drive_fault = cause[0];
   assign drive_power_loss = cause[1];
   assign coast_stop = cause[2];
   assign modulation_on = ~|cause;
   // Ramp and coast steps move speed only every fourth cycle to suit the input synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick <= 2'h0;
         speed_valid <= 1'b0;
         speed <= 16'h0;
      end else begin
         tick <= tick + 2'h1;
         speed_valid <= vld_en;
         if (load) begin
            speed <= tgt;
         end else if (tick == 2'h3 && modulation_on && ramp &&
                      speed > tgt) begin
            speed <= speed - 16'h40;
         end else if (tick == 2'h3 && !modulation_on &&
                      speed > 16'h40) begin
            // Coasting motor settles below trip within the zero-speed delay
            speed <= speed - 16'h40;
         end
      end
   end
endmodule // slm_drive_model

/* verification/slm_top_chk.sv */
`timescale 1ns/1ps
`include "slm_defs.svh"
module slm_top_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic modulation_on,
   input wire logic drive_fault,
   input wire logic drive_power_loss,
   input wire logic coast_stop,
   input wire logic sls_indication,
   input wire logic limit_hit,
   input wire logic restart_block,
   input wire logic sto_request,
   input wire logic ack_accepted
);
   logic wr_pend;
   logic mode_dis;
   logic tmon;
   logic lost;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign lost = !modulation_on || drive_fault || drive_power_loss ||
      coast_stop;
   // Shadow of the mode bits seen on control writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         mode_dis <= 1'b1;
         tmon <= 1'b0;
      end else begin
         wr_pend <= hsel && hready && htrans[1] && hwrite
            && haddr[7:0] == `SLM_OFF_CTRL;
         if (wr_pend) begin
            mode_dis <= hwdata[3:2] == 2'h2;
            tmon <= hwdata[4];
         end
      end
   end
   sequence s_lost;
      lost [*3];
   endsequence
   a_hit_single_pulse: assert property (limit_hit |=> !limit_hit)
      else $error("limit hit longer than one cycle");
   a_hit_then_sto: assert property (limit_hit |-> ##[0:2] sto_request)
      else $error("limit hit without torque off");
   a_sto_needs_hit: assert property ($rose(sto_request) |->
      limit_hit || $past(limit_hit))
      else $error("torque off without limit hit");
   a_loss_no_sto: assert property ((mode_dis && !tmon) throughout
      s_lost |=> !$rose(sto_request))
      else $error("torque off on modulation loss");
   a_ack_one_pulse: assert property (ack_accepted |=> !ack_accepted)
      else $error("ack pulse too long");
   a_ack_not_blocked: assert property (ack_accepted |-> !restart_block)
      else $error("ack accepted during boot wait");
   a_release_ind: assert property ($fell(restart_block) |->
      ##[0:1] sls_indication)
      else $error("no indication at boot release");
   a_block_no_ind: assert property (restart_block |-> !sls_indication)
      else $error("indication during boot wait");
endmodule // slm_top_chk
bind slm_top slm_top_chk u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hwdata(hwdata), .modulation_on(modulation_on),
   .drive_fault(drive_fault), .drive_power_loss(drive_power_loss),
   .coast_stop(coast_stop), .sls_indication(sls_indication),
   .limit_hit(limit_hit), .restart_block(restart_block),
   .sto_request(sto_request), .ack_accepted(ack_accepted));

/* verification/tb_top.sv */
`timescale 1ns/1ps
`include "slm_defs.svh"
module tb_top;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
   logic [1:0] htrans = 2'h0;
   logic hreadyout, hresp, mod_on, flt, pwr, cst, vld, ind, hit, rblk, sto;
   logic ack, irq, vld_en = 1'b0, load = 1'b0, ramp = 1'b0;
   logic [2:0] cause = 3'h0;
   logic [15:0] tgt = 16'h0, spd;
   int bad_count = 0, cmp_count = 0, hit_cnt = 0, ack_cnt = 0, i;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h20};
   logic [31:0] rv [7] = '{32'h8, 32'h1000, 32'h1400, 32'h1000, 32'h1000,
      32'h0, 32'h0};
   always #4 hclk = ~hclk;
   slm_top u_slm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(`SLM_HSIZE_WORD),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .modulation_on(mod_on),
      .drive_fault(flt), .drive_power_loss(pwr), .coast_stop(cst),
      .speed_valid(vld), .speed(spd), .sls_indication(ind), .limit_hit(hit),
      .restart_block(rblk), .sto_request(sto), .ack_accepted(ack), .irq(irq));
   slm_drive_model u_slm_drive_model (.hclk(hclk), .hresetn(hresetn),
      .vld_en(vld_en), .load(load), .ramp(ramp), .cause(cause), .tgt(tgt),
      .modulation_on(mod_on), .drive_fault(flt), .drive_power_loss(pwr),
      .coast_stop(cst), .speed_valid(vld), .speed(spd));
   always @(posedge hclk) begin
      if (hit === 1'b1) hit_cnt++;
      if (ack === 1'b1) ack_cnt++;
   end
   task automatic bus(input logic [7:0] a, input logic w,
         input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(a, 1'b1, v, x);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] v, input int n);
      logic [31:0] x;
      for (int k = 0; k < n; k++) begin
         bus(a, 1'b0, 32'h0, x);
         if ((x & m) === v) break;
      end
      chk(x & m, v);
   endtask
   task automatic set_speed(input logic [15:0] v);
      tgt <= v;
      load <= 1'b1;
      @(posedge hclk);
      load <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge hclk);
      bad_count++;
      results();
   end
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      wr(8'h20, 32'hFFFF_FFFF);
      for (i = 0; i < 7; i++) poll(ra[i], 32'hFFFF_FFFF, rv[i], 1);
      chk(hresp, `SLM_HRESP_OKAY);
      poll(`SLM_OFF_STATUS, 32'hFFFF_003F, 32'hFFFF_0001, 1);
      // Boot wait with an early acknowledge
      wr(`SLM_OFF_LS_DELAY, 32'h8);
      wr(`SLM_OFF_ZS_DELAY, 32'd20);
      vld_en <= 1'b1;
      set_speed(16'h0800);
      wr(`SLM_OFF_CTRL, 32'h1);
      repeat (4) @(posedge hclk);
      chk(rblk, 1'b1);
      poll(`SLM_OFF_STATUS, 32'h3F, 32'h20, 1);
      wr(`SLM_OFF_CTRL, 32'h3);
      repeat (16) @(posedge hclk);
      chk(rblk, 1'b1);
      chk(ack_cnt, 0);
      poll(`SLM_OFF_IRQ_STATUS, 32'h8, 32'h8, 1);
      poll(`SLM_OFF_STATUS, 32'h80, 32'h0, 40);
      chk(ind, 1'b1);
      wr(`SLM_OFF_IRQ_MASK, 32'h8);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1);
      wr(`SLM_OFF_IRQ_STATUS, 32'h8);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b0);
      wr(`SLM_OFF_CTRL, 32'h8);
      // Loss in disabled mode, one pass per loss cause
      wr(`SLM_OFF_ZS_DELAY, 32'd80);
      for (i = 0; i < 3; i++) begin
         set_speed(16'h1800);
         wr(`SLM_OFF_CTRL, 32'h9);
         poll(`SLM_OFF_STATUS, 32'h203F, 32'h2002, 4);
         cause <= 3'h1 << i;
         repeat (6) @(posedge hclk);
         poll(`SLM_OFF_STATUS, 32'h103F, 32'h1004, 1);
         repeat (16) @(posedge hclk);
         chk(sto, 1'b0);
         poll(`SLM_OFF_STATUS, 32'h3F, 32'h4, 1);
         poll(`SLM_OFF_STATUS, 32'h3F, 32'h8, 40);
         chk(ind, 1'b1);
         wr(`SLM_OFF_CTRL, 32'h8);
         cause <= 3'h0;
      end
      // Return of modulation, ramp down to the midpoint
      wr(`SLM_OFF_LS_DELAY, 32'd400);
      wr(`SLM_OFF_ZS_DELAY, 32'd300);
      set_speed(16'h1800);
      tgt <= 16'h1000;
      ramp <= 1'b1;
      wr(`SLM_OFF_CTRL, 32'h9);
      cause <= 3'h1;
      repeat (10) @(posedge hclk);
      cause <= 3'h0;
      poll(`SLM_OFF_STATUS, 32'h40, 32'h40, 150);
      bus(`SLM_OFF_STATUS, 1'b0, 32'h0, d);
      chk(d & 32'h23F, 32'h8);
      chk(d[31:16] <= 16'h1200, 1'b1);
      wr(`SLM_OFF_CTRL, 32'h8);
      ramp <= 1'b0;
      // Speed between midpoint and trip, delay expiry starts monitoring
      wr(`SLM_OFF_LS_DELAY, 32'h8);
      set_speed(16'h1800);
      wr(`SLM_OFF_CTRL, 32'h9);
      set_speed(16'h1300);
      repeat (16) @(posedge hclk);
      poll(`SLM_OFF_STATUS, 32'h27F, 32'h248, 1);
      wr(`SLM_OFF_CTRL, 32'h8);
      // Time monitored, modulation back late above trip
      set_speed(16'h1800);
      wr(`SLM_OFF_IRQ_MASK, 32'h1);
      wr(`SLM_OFF_CTRL, 32'h19);
      cause <= 3'h2;
      repeat (30) @(posedge hclk);
      chk(hit_cnt, 0);
      cause <= 3'h0;
      poll(`SLM_OFF_STATUS, 32'h13F, 32'h110, 20);
      chk(hit_cnt, 1);
      chk(irq, 1'b1);
      poll(`SLM_OFF_STATUS, 32'h1000, 32'h0, 300);
      set_speed(16'h0800);
      wr(`SLM_OFF_CTRL, 32'hA);
      repeat (4) @(posedge hclk);
      chk(ack_cnt, 1);
      chk(sto, 1'b0);
      wr(`SLM_OFF_IRQ_STATUS, 32'hF);
      // Frozen estimate in monitoring-active mode
      set_speed(16'h1800);
      wr(`SLM_OFF_CTRL, 32'h5);
      repeat (4) @(posedge hclk);
      cause <= 3'h4;
      repeat (40) @(posedge hclk);
      poll(`SLM_OFF_STATUS, 32'hFFFF_0000, 32'h1800_0000, 1);
      cause <= 3'h0;
      results();
   end
endmodule // tb_top
